// >>> src/sgmii_rx_elastic_buffer.sv
// Receive elastic buffer between recovered-clock symbols and the core.
// Assumes rx_clk and rx_word come from outside; rd_tick and out_ready
// are core logic on clk.
module sgmii_rx_elastic_buffer #(
	parameter bit USE_LOGIC_BUFFER = 1'b1,
	parameter int DEPTH = USE_LOGIC_BUFFER ?
		2 * rx_elastic_pkg::XCVR_DEPTH : rx_elastic_pkg::XCVR_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   rx_clk,
	input  wire rx_elastic_pkg::word_t  rx_word,
	input  wire logic                   rd_tick,
	input  wire logic                   out_ready,
	output rx_elastic_pkg::word_t       out_word_q,
	output logic                        out_valid_q,
	output logic                        overflow_q,
	output logic                        underflow_q,
	output logic [CW-1:0]               level_q,
	output logic                        margin_10m_ok_q
);

	localparam int AW   = $clog2(DEPTH);
	localparam int HALF = DEPTH / 2;
	localparam logic [CW-1:0] HALF_C = CW'(HALF);
	localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_C  = CW'(1);
	// Depth choice against the 10 Mb/s and closely-related margins
	localparam bit SAFE_10M = HALF >= rx_elastic_pkg::MARGIN_200PPM;
	localparam bit SAFE_REL = HALF >= rx_elastic_pkg::MARGIN_100PPM;

	// Match a symbol against a control or data code
	function automatic logic is_sym(input rx_elastic_pkg::word_t w,
		input logic k, input logic [7:0] code);
		is_sym = (w.k == k) && (w.d == code);
	endfunction

	logic                   clk_s1_q;
	logic                   clk_s2_q;
	logic                   clk_s3_q;
	rx_elastic_pkg::word_t  w_s1_q;
	rx_elastic_pkg::word_t  w_s2_q;
	rx_elastic_pkg::word_t  pend_q;
	logic                   pend_v_q;
	logic                   wframe_q;
	logic                   rframe_q;
	logic                   ins_q;
	logic                   pop_q;
	logic [AW-1:0]          wr_ptr_q;
	logic [AW-1:0]          rd_ptr_q;
	logic [CW-1:0]          count_q;
	logic [CW-1:0]          cnt_rd_q;
	logic [CW-1:0]          count_d;
	rx_elastic_pkg::word_t  head;
	rx_elastic_pkg::word_t  e1_q;
	logic                   v1_q;

	// Link clock and symbol pass two flops before use
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			w_s1_q   <= '0;
			w_s2_q   <= '0;
		end
		else
		begin
			clk_s1_q <= rx_clk;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			w_s1_q   <= rx_word;
			w_s2_q   <= w_s1_q;
		end
	end

	// Symbols are taken on the falling link edge, mid-way through their
	// stable period, so the value used was captured half a link period from any change.
	wire                  link_fall = clk_s3_q & ~clk_s2_q;
	wire rx_elastic_pkg::word_t cur = w_s2_q;

	// Write side decode: idle pair held in pending plus current symbol
	wire pair_idle = pend_v_q
		&& is_sym(pend_q, 1'b1, rx_elastic_pkg::IDLE_K)
		&& is_sym(cur, 1'b0, rx_elastic_pkg::IDLE_D);
	wire del_pair  = link_fall && pair_idle && !wframe_q
		&& (count_q > HALF_C);
	wire full      = (count_q == FULL_C);
	wire wr_try    = link_fall && pend_v_q && !del_pair;
	wire wr_en     = wr_try && !full;
	wire cur_sof   = is_sym(cur, 1'b1, rx_elastic_pkg::SOF_K);
	wire cur_eof   = is_sym(cur, 1'b1, rx_elastic_pkg::EOF_K);

	// Pending symbol, frame tracking, write pointer
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pend_q   <= '0;
			pend_v_q <= 1'b0;
			wframe_q <= 1'b0;
			wr_ptr_q <= '0;
		end
		else if (link_fall)
		begin
			pend_q   <= cur;
			pend_v_q <= !del_pair;
			wframe_q <= cur_sof | (wframe_q & ~cur_eof);
			if (wr_en)
				wr_ptr_q <= wr_ptr_q + AW'(1);
		end
	end

	// One memory holds every entry
	rx_elastic_mem #(
		.W     ($bits(rx_elastic_pkg::word_t)),
		.DEPTH (DEPTH)
	) u_mem (
		.clk     (clk),
		.nrst    (nrst),
		.we      (wr_en),
		.waddr   (wr_ptr_q),
		.wdata   (pend_q),
		.raddr   (rd_ptr_q),
		.rdata_q (head)
	);

	// Read side decode; memory data trail the pointer by one cycle
	wire head_ok   = (cnt_rd_q != '0) && !pop_q;
	wire room      = !v1_q;
	wire slot      = rd_tick && room;
	wire head_idle = is_sym(head, 1'b1, rx_elastic_pkg::IDLE_K);
	wire do_ins    = slot && !ins_q && head_ok && head_idle && !rframe_q
		&& (count_q < HALF_C);
	wire pop       = slot && !ins_q && head_ok && !do_ins;
	wire push      = slot && (ins_q || head_ok);
	wire starve    = rd_tick && room && !ins_q && !head_ok;
	wire rx_elastic_pkg::word_t push_w = ins_q
		? rx_elastic_pkg::word_t'{k: 1'b0, d: rx_elastic_pkg::IDLE_D}
		: head;
	wire push_sof  = is_sym(push_w, 1'b1, rx_elastic_pkg::SOF_K);
	wire push_eof  = is_sym(push_w, 1'b1, rx_elastic_pkg::EOF_K);

	// Occupancy: one up per write, one down per pop
	assign count_d = count_q + (wr_en ? ONE_C : '0) - (pop ? ONE_C : '0);

	// Read pointer, insertion state, occupancy
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_ptr_q <= '0;
			ins_q    <= 1'b0;
			pop_q    <= 1'b0;
			rframe_q <= 1'b0;
			count_q  <= '0;
			cnt_rd_q <= '0;
		end
		else
		begin
			if (pop)
				rd_ptr_q <= rd_ptr_q + AW'(1);
			if (slot)
				ins_q <= do_ins;
			if (push)
				rframe_q <= push_sof | (rframe_q & ~push_eof);
			pop_q    <= pop;
			count_q  <= count_d;
			cnt_rd_q <= count_q;
		end
	end

	// Two-entry output buffer so a core stall loses no symbol
	wire out_fire = out_valid_q && out_ready;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_word_q  <= '0;
			out_valid_q <= 1'b0;
			e1_q        <= '0;
			v1_q        <= 1'b0;
		end
		else if (out_fire)
		begin
			out_word_q  <= v1_q ? e1_q : push_w;
			out_valid_q <= v1_q | push;
			e1_q        <= push_w;
			v1_q        <= v1_q & push;
		end
		else if (push)
		begin
			if (out_valid_q)
			begin
				e1_q <= push_w;
				v1_q <= 1'b1;
			end
			else
			begin
				out_word_q  <= push_w;
				out_valid_q <= 1'b1;
			end
		end
	end

	// Status flags and occupancy report
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			overflow_q      <= 1'b0;
			underflow_q     <= 1'b0;
			level_q         <= '0;
			margin_10m_ok_q <= 1'b0;
		end
		else
		begin
			overflow_q      <= wr_try && full;
			underflow_q     <= starve;
			level_q         <= count_q;
			margin_10m_ok_q <= SAFE_10M;
		end
	end

	// Smaller buffer still covers the closely-related clock case
	wire unused_rel = SAFE_REL;

endmodule

// >>> src/rx_elastic_pkg.sv
// Constants and carrier types for the receive elastic buffer.
// Assumes 8b/10b decoded symbols arrive one per link clock period.
// What this block does
// - Logic buffer lives in one memory, twice the 64-entry transceiver buffer.
// - Build option picks logic buffer by default, else smaller transceiver-sized one.
// - In the gap after a frame, idles are deleted until half full returns.
// - Bytes repeated 10 or 100 times at slow rates pass unharmed.
// - At 10 Mb/s with 200 ppm, 31 entries margin each side of half.
// - Small buffer only when 10 Mb/s unused or clocks closely related.
// - With 100 ppm total mismatch, 16 entries margin each side suffice.
// - Write side takes symbols timed by the recovered receive clock.
// - Read side and core logic run on the core clock.
package rx_elastic_pkg;

	// Symbol as decoded: control flag and byte
	typedef struct packed {
		logic       k;
		logic [7:0] d;
	} word_t;

	localparam int XCVR_DEPTH    = 64;
	localparam int MARGIN_200PPM = 31;
	localparam int MARGIN_100PPM = 16;
	localparam int REP_100M      = 10;
	localparam int REP_10M       = 100;
	localparam int FRAME_MAX     = 1522;
	localparam int CORE_CLK_MHZ  = 125;

	// Code groups that matter to the gap logic
	localparam logic [7:0] IDLE_K = 8'hbc;
	localparam logic [7:0] IDLE_D = 8'h50;
	localparam logic [7:0] SOF_K  = 8'hfb;
	localparam logic [7:0] EOF_K  = 8'hfd;

endpackage

// >>> src/rx_elastic_mem.sv
// Simple dual-port memory for the elastic buffer.
// Assumes one clock; read data come out of a register.
module rx_elastic_mem #(
	parameter int W     = 9,
	parameter int DEPTH = 128,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_q
);

	logic [W-1:0] mem [DEPTH];

	// Storage array, no reset
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// Registered read port
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= '0;
		else
			rdata_q <= mem[raddr];
	end

endmodule

// >>> test/rx_elastic_checker.sv
// Port assertions for the receive elastic buffer.
// Assumes it is bound into every buffer instance.
module rx_elastic_checker #(
	parameter int DEPTH = 128,
	parameter int CW    = 8
) (
	input wire logic			clk,
	input wire logic			nrst,
	input wire logic			rd_tick,
	input wire logic			out_ready,
	input wire rx_elastic_pkg::word_t	out_word_q,
	input wire logic			out_valid_q,
	input wire logic			overflow_q,
	input wire logic			underflow_q,
	input wire logic [CW-1:0]		level_q,
	input wire logic			margin_10m_ok_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Occupancy, flags and output holding
	level_max_a: assert property (level_q <= DEPTH)
		else $error("level over depth");
	margin_a: assert property (
		$past(nrst) |-> margin_10m_ok_q ==
		(DEPTH / 2 >= rx_elastic_pkg::MARGIN_200PPM))
		else $error("margin flag wrong");
	level_step_a: assert property (
		$past(nrst) |-> level_q <= $past(level_q) + 1 &&
		level_q + 1 >= $past(level_q)) else $error("level jump");
	out_hold_a: assert property (
		out_valid_q && !out_ready |=> out_valid_q && $stable(out_word_q))
		else $error("output not held");
	under_cause_a: assert property (underflow_q |-> $past(rd_tick))
		else $error("underflow without slot");
	over_gap_a: assert property (overflow_q |=> !overflow_q [*4])
		else $error("overflow too often");
	over_full_a: assert property (overflow_q |-> level_q >= DEPTH - 2)
		else $error("overflow below full");
	valid_cause_a: assert property (
		$rose(out_valid_q) |-> $past(rd_tick)) else $error("valid unasked");
endmodule
bind sgmii_rx_elastic_buffer rx_elastic_checker #(.DEPTH(DEPTH), .CW(CW)) chk (
	.clk(clk), .nrst(nrst), .rd_tick(rd_tick), .out_ready(out_ready),
	.out_word_q(out_word_q), .out_valid_q(out_valid_q),
	.overflow_q(overflow_q), .underflow_q(underflow_q),
	.level_q(level_q), .margin_10m_ok_q(margin_10m_ok_q));

// >>> test/rx_link_model.sv
// Link partner: recovered clock and decoded symbol stream.
// Assumes the buffer samples symbols on the falling link edge.
module rx_link_model (
	output logic			rx_clk,
	output rx_elastic_pkg::word_t	rx_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] n;
	// New symbol just after the rising edge
	task automatic put(input logic k, input logic [7:0] d);
		@(posedge rx_clk);
		rx_word = '{k, d};
	endtask
	task automatic pair();
		put(1'b1, rx_elastic_pkg::IDLE_K);
		put(1'b0, rx_elastic_pkg::IDLE_D);
	endtask
	// Free-running recovered clock
	initial
	begin
		rx_clk = 1'b0;
		forever #24 rx_clk = ~rx_clk;
	end
	// Idle gap, then counting bytes each sent ten times
	initial
	begin
		n = 8'h00;
		rx_word = '{1'b1, rx_elastic_pkg::IDLE_K};
		repeat (24) pair();
		forever
		begin
			put(1'b1, rx_elastic_pkg::SOF_K);
			repeat (12)
			begin
				repeat (rx_elastic_pkg::REP_100M) put(1'b0, n);
				n++;
			end
			put(1'b1, rx_elastic_pkg::EOF_K);
			repeat (16) pair();
		end
	end
endmodule

// >>> test/testbench.sv
// Bench: link model in, core reads at two rates, then a stall.
// Assumes package, design, checker and link model compiled first.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	error_cnt++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, rx_clk, rd_tick, out_ready, valid, ovf, und, ok;
	rx_elastic_pkg::word_t rx_word, ow;
	logic [7:0] lvl, last = 8'h00, mx = 8'h00;
	logic [31:0] lf = 32'hc616;
	int error_cnt, comparisons, n_dat, n_frm, n_ovf, n_und, per = 11, cyc;
	bit in_frm, chk_on = 1;
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic next_ok(input logic [7:0] p, d);
		return d == p || d == p + 8'h01;
	endfunction
	task automatic report_and_stop;
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	rx_link_model link (.rx_clk(rx_clk), .rx_word(rx_word));
	sgmii_rx_elastic_buffer DUT (.clk(clk), .nrst(nrst), .rx_clk(rx_clk),
		.rx_word(rx_word), .rd_tick(rd_tick), .out_ready(out_ready),
		.out_word_q(ow), .out_valid_q(valid), .overflow_q(ovf),
		.underflow_q(und), .level_q(lvl), .margin_10m_ok_q(ok));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Read slots every per+1 cycles, random output stalls
	always @(negedge clk)
	begin
		lf = step(lf);
		cyc++;
		rd_tick = nrst && per != 0 && cyc % (per + 1) == 0;
		out_ready = |lf[1:0];
		// Frames must leave whole and in order; judged on settled outputs
		// against the transfer that the next rising edge makes
		n_ovf += (nrst && ovf === 1'b1);
		n_und += (nrst && und === 1'b1);
		if (nrst && lvl > mx)
			mx = lvl;
		if (nrst && chk_on && valid && out_ready)
		begin
			if (ow.k && ow.d == rx_elastic_pkg::EOF_K && in_frm)
			begin
				`CHK("frame length", 120, n_dat)
				n_frm++;
			end
			if (in_frm && !ow.k)
			begin
				`CHK("byte order", 1'b1, next_ok(last, ow.d))
				last = ow.d;
				n_dat++;
			end
			if (ow.k)
				in_frm = ow.d == rx_elastic_pkg::SOF_K;
			if (ow.k)
				n_dat = 0;
		end
	end
	initial
	begin
		nrst = 1'b0;
		rd_tick = 1'b0;
		out_ready = 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk) nrst = 1'b1;
		#60us per = 6;
		#60us;
		`CHK("overflow count", 0, n_ovf)
		`CHK("peak above half", 1'b1, mx > 8'h40)
		`CHK("peak below full", 1'b1, mx < 8'h80)
		`CHK("frames seen", 1'b1, n_frm > 10)
		`CHK("margin flag", 1'b1, ok)
		`CHK("underflow seen", 1'b1, n_und > 0)
		chk_on = 0;
		per = 0;
		#12us;
		`CHK("overflow on stall", 1'b1, n_ovf > 0)
		report_and_stop;
	end
	// Watchdog well past the planned run
	initial
	begin
		#200us;
		error_cnt++;
		report_and_stop;
	end
endmodule
